// [include/port_cell_pkg.sv]
// shared constants, register map and carriers for the port pin configuration block
`default_nettype none
package port_cell_pkg;
	localparam int unsigned NUM_PORTS = 8;
	localparam int unsigned PORT_BITS = 8;
	localparam int unsigned NUM_PINS = NUM_PORTS * PORT_BITS;
	localparam int unsigned ADDR_W = 8;

	// register word byte addresses, one aligned word each
	localparam logic [ADDR_W-1:0] OFS_ANALOG_DIGITAL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_OUTPUT_MODE = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_OUTPUT_LATCH = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_DRIVE_STRENGTH = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_BYPASS = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_PIN_READ = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_EVENT_FLAGS = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_GLOBAL_CTRL = 8'h1c;
	localparam logic [ADDR_W-1:0] PORT_STRIDE = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_PORT_FIELD_MASK = 8'h1f;
	localparam logic [ADDR_W-1:0] OFS_PORT_SEL_MASK = 8'he0;
	localparam int unsigned PORT_SEL_LSB = 5;

	// reset values per port byte
	localparam logic [7:0] RST_ANALOG_DIGITAL = 8'hff;
	localparam logic [7:0] RST_OUTPUT_MODE = 8'h00;
	localparam logic [7:0] RST_OUTPUT_LATCH = 8'hff;
	localparam logic [7:0] RST_DRIVE_STRENGTH = 8'h00;
	localparam logic [7:0] RST_BYPASS = 8'h00;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	// synchroniser reset level matches the pulled-up idle pad, so reset makes no false edge
	localparam logic PAD_IDLE_LEVEL = 1'b1;

	// global control fields
	localparam int unsigned BIT_PULLUP_DISABLE = 0;
	localparam int unsigned BIT_EXT_MEMORY = 1;

	// pins that the crossbar may allocate: ports 0..2
	localparam logic [NUM_PINS-1:0] CROSSBAR_RANGE = 64'h0000_0000_00ff_ffff;
	// fixed-location pins: first uart P0.4,P0.5 and second spi P2.0..P2.3
	localparam logic [NUM_PINS-1:0] FIXED_UART_PINS = 64'h0000_0000_0000_0030;
	localparam logic [NUM_PINS-1:0] FIXED_SPI_PINS = 64'h0000_0000_000f_0000;
	// external memory interface range P3.6..P6.7
	localparam logic [NUM_PINS-1:0] EXT_MEMORY_PINS = 64'h00ff_ffff_c000_0000;
	// debug data pin P7.0
	localparam int unsigned DEBUG_PIN = 56;

	// per-pin pad controls that travel together
	typedef struct packed {
		logic drive_oe;
		logic drive_out;
		logic pullup_en;
		logic receiver_en;
		logic high_drive;
	} pad_ctrl_t;

	// bus read response carrier
	typedef struct packed {
		logic valid;
		logic [31:0] data;
	} read_resp_t;
endpackage
`default_nettype wire

// [rtl/pin_cell.sv]
// one port pin cell: pad control, input synchroniser and edge capture
`timescale 1ns/100ps
`default_nettype none
module pin_cell (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_digital, // 1 digital, 0 analog
	input wire logic i_push_pull, // output mode select
	input wire logic i_out_value, // latch or peripheral value
	input wire logic i_out_enable, // driver permitted
	input wire logic i_high_drive,
	input wire logic i_pullup_disable,
	input wire logic i_pad_in,
	output var port_cell_pkg::pad_ctrl_t o_pad,
	output logic o_level,
	output logic o_edge
);
	logic sync1_q; // first synchroniser stage, read only by sync2_q
	logic sync2_q;
	logic prev_q; // previous synchronised level for edge detect
	logic drive_oe; // cell drives pad this cycle
	logic drive_out;

	// driver: push-pull drives both levels, open drain only low
	always_comb begin
		drive_oe = 1'b0;
		drive_out = 1'b0;
		if (i_digital && i_out_enable) begin
			if (i_push_pull) begin
				drive_oe = 1'b1;
				drive_out = i_out_value;
			end else begin
				drive_oe = ~i_out_value;
				drive_out = 1'b0;
			end
		end
	end

	// pad control bundle; pullup only while digital and not driving
	always_comb begin
		o_pad.drive_oe = drive_oe;
		o_pad.drive_out = drive_out;
		o_pad.pullup_en = i_digital && !drive_oe && !i_pullup_disable;
		o_pad.receiver_en = i_digital;
		o_pad.high_drive = i_high_drive;
	end

	// two-stage synchroniser; receiver gated by digital select
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			sync1_q <= port_cell_pkg::PAD_IDLE_LEVEL; // pulled-up pad reads high after reset
			sync2_q <= port_cell_pkg::PAD_IDLE_LEVEL;
		end else begin
			sync1_q <= i_pad_in & i_digital;
			sync2_q <= sync1_q;
		end
	end

	// edge history; analog pins hold zero so never create events
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			prev_q <= port_cell_pkg::PAD_IDLE_LEVEL; // same as sync2_q, no event on release
		end else begin
			prev_q <= sync2_q;
		end
	end

	assign o_level = sync2_q & i_digital;
	assign o_edge = i_digital && (sync2_q != prev_q);
endmodule
`default_nettype wire

// [rtl/port_pin_config_cell.sv]
// port pin configuration block: eight byte-wide ports behind an avalon-mm slave
//
// The Avalon-MM interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module port_pin_config_cell (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// avalon-mm slave
	input wire logic [port_cell_pkg::ADDR_W-1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// pads, six signals each
	input wire logic [port_cell_pkg::NUM_PINS-1:0] i_pad_in,
	output logic [port_cell_pkg::NUM_PINS-1:0] o_pad_out,
	output logic [port_cell_pkg::NUM_PINS-1:0] o_pad_oe,
	output logic [port_cell_pkg::NUM_PINS-1:0] o_pad_pullup_en,
	output logic [port_cell_pkg::NUM_PINS-1:0] o_pad_receiver_en,
	output logic [port_cell_pkg::NUM_PINS-1:0] o_pad_high_drive,
	// crossbar and peripheral side
	input wire logic i_crossbar_enable,
	input wire logic [port_cell_pkg::NUM_PINS-1:0] i_crossbar_claim,
	input wire logic [port_cell_pkg::NUM_PINS-1:0] i_crossbar_out,
	input wire logic [port_cell_pkg::NUM_PINS-1:0] i_crossbar_oe,
	output logic [port_cell_pkg::NUM_PINS-1:0] o_crossbar_allowed,
	output logic [port_cell_pkg::NUM_PINS-1:0] o_pin_level,
	// external memory interface direct pins
	input wire logic [port_cell_pkg::NUM_PINS-1:0] i_ext_memory_out,
	input wire logic [port_cell_pkg::NUM_PINS-1:0] i_ext_memory_oe,
	// debug data line on P7.0
	input wire logic i_debug_data_active,
	input wire logic i_debug_data_out,
	input wire logic i_debug_data_oe,
	output logic o_debug_data_in,
	// edge events towards interrupt and wake logic
	output logic [port_cell_pkg::NUM_PINS-1:0] o_pin_edge,
	output logic o_event_any
);
	localparam int unsigned NP = port_cell_pkg::NUM_PINS;
	localparam int unsigned NB = port_cell_pkg::NUM_PORTS;

	logic [NP-1:0] analog_digital_q; // pin_analog_digital_select
	logic [NP-1:0] output_mode_q; // pin_output_mode_select
	logic [NP-1:0] output_latch_q; // gpio output latch
	logic [NP-1:0] drive_strength_q; // pin_drive_strength_select
	logic [NP-1:0] bypass_q; // crossbar_pin_bypass
	logic [NP-1:0] event_flags_q; // sticky edge flags
	logic weak_pullup_global_disable_q;
	logic ext_memory_pin_config_q; // routes ext memory onto its range
	logic [NP-1:0] digital_eff; // effective digital select
	logic [NP-1:0] level;
	logic [NP-1:0] edge_hit;
	logic [NP-1:0] out_value;
	logic [NP-1:0] out_enable;
	logic [NP-1:0] ext_mem_sel;
	logic [NP-1:0] xbar_sel;
	logic [NP-1:0] dbg_sel;
	logic [NB-1:0] port_hit; // one-hot port decode
	localparam int unsigned ADDR_W_L = port_cell_pkg::ADDR_W;
	logic [ADDR_W_L-1:0] field; // register offset inside the port slot
	logic wr_ad, wr_om, wr_ol, wr_ds, wr_bp, wr_ev, wr_gc;
	logic [7:0] wr_byte;
	logic [31:0] rdata_d;
	logic [31:0] rdata_q;
	logic ack_q; // one wait state on every access

	assign field = i_avs_address & port_cell_pkg::OFS_PORT_FIELD_MASK;
	assign wr_byte = i_avs_writedata[7:0]; // narrow data in low lane

	// field decode for the current write, taken on the acknowledge edge
	always_comb begin
		wr_ad = 1'b0;
		wr_om = 1'b0;
		wr_ol = 1'b0;
		wr_ds = 1'b0;
		wr_bp = 1'b0;
		wr_ev = 1'b0;
		wr_gc = 1'b0;
		if (i_avs_write && ack_q && i_avs_byteenable[0]) begin
			if (field == port_cell_pkg::OFS_ANALOG_DIGITAL) begin
				wr_ad = 1'b1;
			end else if (field == port_cell_pkg::OFS_OUTPUT_MODE) begin
				wr_om = 1'b1;
			end else if (field == port_cell_pkg::OFS_OUTPUT_LATCH) begin
				wr_ol = 1'b1;
			end else if (field == port_cell_pkg::OFS_DRIVE_STRENGTH) begin
				wr_ds = 1'b1;
			end else if (field == port_cell_pkg::OFS_BYPASS) begin
				wr_bp = 1'b1;
			end else if (field == port_cell_pkg::OFS_EVENT_FLAGS) begin
				wr_ev = 1'b1;
			end else if (field == port_cell_pkg::OFS_GLOBAL_CTRL) begin
				wr_gc = 1'b1;
			end
		end
	end

	// wait-state generator: waitrequest drops one cycle after request rises
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= (i_avs_read || i_avs_write) && !ack_q;
		end
	end
	assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_q;

	// per-port byte registers, eight ports of eight bits
	genvar p;
	generate
		for (p = 0; p < NB; p++) begin : g_port
			assign port_hit[p] = ((i_avs_address & port_cell_pkg::OFS_PORT_SEL_MASK)
				>> port_cell_pkg::PORT_SEL_LSB) == ADDR_W_L'(p);
			always_ff @(posedge i_clk_sys) begin
				if (!i_rst_n) begin
					analog_digital_q[p*8 +: 8] <= port_cell_pkg::RST_ANALOG_DIGITAL;
					output_mode_q[p*8 +: 8] <= port_cell_pkg::RST_OUTPUT_MODE;
					output_latch_q[p*8 +: 8] <= port_cell_pkg::RST_OUTPUT_LATCH;
					drive_strength_q[p*8 +: 8] <= port_cell_pkg::RST_DRIVE_STRENGTH;
					bypass_q[p*8 +: 8] <= port_cell_pkg::RST_BYPASS;
				end else if (port_hit[p]) begin
					if (wr_ad) analog_digital_q[p*8 +: 8] <= wr_byte;
					if (wr_om) output_mode_q[p*8 +: 8] <= wr_byte;
					if (wr_ol) output_latch_q[p*8 +: 8] <= wr_byte;
					if (wr_ds) drive_strength_q[p*8 +: 8] <= wr_byte;
					if (wr_bp) bypass_q[p*8 +: 8] <= wr_byte;
				end
			end
			// sticky edge flags, write one to clear; a new edge beats the clear
			always_ff @(posedge i_clk_sys) begin
				if (!i_rst_n) begin
					event_flags_q[p*8 +: 8] <= port_cell_pkg::BYTE_ZERO;
				end else if (wr_ev && port_hit[p]) begin
					event_flags_q[p*8 +: 8] <= (event_flags_q[p*8 +: 8] & ~wr_byte)
						| edge_hit[p*8 +: 8];
				end else begin
					event_flags_q[p*8 +: 8] <= event_flags_q[p*8 +: 8] | edge_hit[p*8 +: 8];
				end
			end
		end
	endgenerate

	// global controls live only in the port 0 slot
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			weak_pullup_global_disable_q <= 1'b0;
			ext_memory_pin_config_q <= 1'b0;
		end else if (wr_gc && port_hit[0]) begin
			weak_pullup_global_disable_q <= wr_byte[port_cell_pkg::BIT_PULLUP_DISABLE];
			ext_memory_pin_config_q <= wr_byte[port_cell_pkg::BIT_EXT_MEMORY];
		end
	end

	// pin source selection; debug owns P7.0 while active, ext memory its range
	always_comb begin
		dbg_sel = '0;
		dbg_sel[port_cell_pkg::DEBUG_PIN] = i_debug_data_active;
		ext_mem_sel = ext_memory_pin_config_q ? port_cell_pkg::EXT_MEMORY_PINS : '0;
		// crossbar only on allowed pins that it actually claims
		xbar_sel = i_crossbar_claim & o_crossbar_allowed & {NP{i_crossbar_enable}};
		digital_eff = analog_digital_q;
		digital_eff[port_cell_pkg::DEBUG_PIN] = 1'b1;
		// ext memory wins over the crossbar, debug wins over everything
		out_value = (output_latch_q & ~ext_mem_sel & ~xbar_sel)
			| (i_ext_memory_out & ext_mem_sel)
			| (i_crossbar_out & xbar_sel & ~ext_mem_sel);
		out_enable = (~ext_mem_sel & ~xbar_sel)
			| (i_ext_memory_oe & ext_mem_sel)
			| (i_crossbar_oe & xbar_sel & ~ext_mem_sel);
		out_value[port_cell_pkg::DEBUG_PIN] = i_debug_data_active ? i_debug_data_out
			: out_value[port_cell_pkg::DEBUG_PIN];
		out_enable[port_cell_pkg::DEBUG_PIN] = i_debug_data_active ? i_debug_data_oe
			: out_enable[port_cell_pkg::DEBUG_PIN];
	end

	// crossbar may use ports 0..2 not bypassed; fixed pins are masked by bypass like the rest
	assign o_crossbar_allowed = port_cell_pkg::CROSSBAR_RANGE & ~bypass_q
		& ~ext_mem_sel;

	// one cell per pin
	genvar n;
	generate
		for (n = 0; n < NP; n++) begin : g_pin
			port_cell_pkg::pad_ctrl_t pad;
			logic push_pull;
			// debug line is forced push-pull while active; otherwise the output mode applies
			assign push_pull = dbg_sel[n] ? 1'b1 : output_mode_q[n];
			pin_cell u_cell (
				.i_clk_sys(i_clk_sys),
				.i_rst_n(i_rst_n),
				.i_digital(digital_eff[n]),
				.i_push_pull(push_pull),
				.i_out_value(out_value[n]),
				.i_out_enable(out_enable[n]),
				.i_high_drive(drive_strength_q[n]),
				.i_pullup_disable(weak_pullup_global_disable_q),
				.i_pad_in(i_pad_in[n]),
				.o_pad(pad),
				.o_level(level[n]),
				.o_edge(edge_hit[n])
			);
			assign o_pad_out[n] = pad.drive_out;
			assign o_pad_oe[n] = pad.drive_oe;
			assign o_pad_pullup_en[n] = pad.pullup_en;
			assign o_pad_receiver_en[n] = pad.receiver_en;
			assign o_pad_high_drive[n] = pad.high_drive;
		end
	endgenerate

	assign o_pin_level = level;
	assign o_pin_edge = edge_hit;
	assign o_event_any = |event_flags_q;
	assign o_debug_data_in = level[port_cell_pkg::DEBUG_PIN];

	// read mux; unmapped fields read zero
	always_comb begin
		rdata_d = '0;
		for (int i = 0; i < NB; i++) begin
			if (port_hit[i]) begin
				if (field == port_cell_pkg::OFS_ANALOG_DIGITAL) begin
					rdata_d[7:0] = analog_digital_q[i*8 +: 8];
				end else if (field == port_cell_pkg::OFS_OUTPUT_MODE) begin
					rdata_d[7:0] = output_mode_q[i*8 +: 8];
				end else if (field == port_cell_pkg::OFS_OUTPUT_LATCH) begin
					rdata_d[7:0] = output_latch_q[i*8 +: 8];
				end else if (field == port_cell_pkg::OFS_DRIVE_STRENGTH) begin
					rdata_d[7:0] = drive_strength_q[i*8 +: 8];
				end else if (field == port_cell_pkg::OFS_BYPASS) begin
					rdata_d[7:0] = bypass_q[i*8 +: 8];
				end else if (field == port_cell_pkg::OFS_PIN_READ) begin
					rdata_d[7:0] = level[i*8 +: 8];
				end else if (field == port_cell_pkg::OFS_EVENT_FLAGS) begin
					rdata_d[7:0] = event_flags_q[i*8 +: 8];
				end else if (field == port_cell_pkg::OFS_GLOBAL_CTRL && i == 0) begin
					rdata_d[port_cell_pkg::BIT_PULLUP_DISABLE] = weak_pullup_global_disable_q;
					rdata_d[port_cell_pkg::BIT_EXT_MEMORY] = ext_memory_pin_config_q;
				end
			end
		end
	end

	// registered read data, loaded in the wait cycle so it stands at the ack edge
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			rdata_q <= '0;
		end else if (i_avs_read && !ack_q) begin
			rdata_q <= rdata_d;
		end
	end
	assign o_avs_readdata = rdata_q;
endmodule
`default_nettype wire

// [verif/port_cell_sva.sv]
// concurrent checks on the ports of the port pin configuration block
`timescale 1ns/100ps
`default_nettype none
module port_cell_sva (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] o_avs_readdata,
	input wire logic o_avs_waitrequest,
	input wire logic [63:0] i_pad_in,
	input wire logic [63:0] o_pad_out,
	input wire logic [63:0] o_pad_oe,
	input wire logic [63:0] o_pad_pullup_en,
	input wire logic [63:0] o_pad_receiver_en,
	input wire logic [63:0] o_pad_high_drive,
	input wire logic [63:0] o_crossbar_allowed,
	input wire logic [63:0] o_pin_level,
	input wire logic [63:0] o_pin_edge,
	input wire logic o_event_any
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	// drive and pull-up on ports 3..6 only: crossbar claims may already drive pins of ports 0..2
	a_reset_pads: assert property ($rose(i_rst_n) |-> o_pad_oe[55:24] == 32'h0 &&
		o_pad_pullup_en[55:24] == '1 && o_pad_receiver_en == '1 && o_pad_high_drive == 64'h0)
		else $error("pads not in reset state");
	// receiver off marks an analog pin, whose pull-up must be off too
	a_analog_quiet: assert property ((o_pad_pullup_en & ~o_pad_receiver_en) == 64'h0)
		else $error("pullup on analog pin");
	// one cycle of slack in case the masking is registered
	a_analog_zero: assert property ((o_pin_level & ~o_pad_receiver_en &
		~$past(o_pad_receiver_en)) == 64'h0) else $error("analog pin reads one");
	a_low_no_pullup: assert property ((o_pad_pullup_en & o_pad_oe & ~o_pad_out) == 64'h0)
		else $error("pullup while driving low");
	// level is the pad seen two edges earlier on steadily digital pins
	a_level_sync: assert property ($past(i_rst_n) && $past(i_rst_n, 2) |->
		((o_pin_level ^ $past(i_pad_in, 2)) & o_pad_receiver_en & $past(o_pad_receiver_en)
		& $past(o_pad_receiver_en, 2)) == 64'h0) else $error("pin level not pad level");
	a_edge_cause: assert property ($past(i_rst_n) |->
		(o_pin_edge & ~(o_pin_level ^ $past(o_pin_level))) == 64'h0) else $error("bogus edge");
	a_edge_seen: assert property ($past(i_rst_n) |-> ((o_pin_level ^ $past(o_pin_level)) &
		o_pad_receiver_en & $past(o_pad_receiver_en) & ~o_pin_edge) == 64'h0) else $error("edge lost");
	a_event_sticky: assert property (|o_pin_edge |=> o_event_any)
		else $error("event flag not raised");
	a_one_wait: assert property ($rose(i_avs_read || i_avs_write) |->
		o_avs_waitrequest ##1 !o_avs_waitrequest) else $error("wait state count wrong");
	a_xbar_range: assert property ((o_crossbar_allowed & ~port_cell_pkg::CROSSBAR_RANGE)
		== 64'h0) else $error("crossbar allowed outside its ports");
	a_read_upper: assert property (o_avs_readdata[31:8] == 24'h0) else $error("upper read bits set");
	c_edge: cover property (|o_pin_edge);
	c_analog: cover property (o_pad_receiver_en != '1);
	c_access: cover property ((i_avs_read || i_avs_write) && !o_avs_waitrequest);
endmodule
`default_nettype wire

// [verif/port_pin_config_cell_bench.sv]
// self-checking bench for the port pin configuration block
`timescale 1ns/100ps
`default_nettype none
module port_pin_config_cell_bench;
	logic clk, rst_n, rd_r, wr_r, wait_o, xen, dba, dbo, dboe, dbi, ev_any;
	logic [7:0] adr, m, l, s, p, oe;
	logic [3:0] ben;
	logic [31:0] wdat, rdata, q, rnd;
	logic [63:0] pad_in, pad_out, pad_oe, pu, rx, hd, xclaim, xout, xoe, xallow, lvl, emo, emoe;
	logic [63:0] edge_v;
	logic [7:0] rv [5] = '{8'hff, 8'h00, 8'hff, 8'h00, 8'h00}; // reset bytes per field
	int err_count = 0;
	int total_checks = 0;
	int cyc = 0;
	port_pin_config_cell dut_u (.i_clk_sys(clk), .i_rst_n(rst_n), .i_avs_address(adr),
		.i_avs_read(rd_r), .i_avs_write(wr_r), .i_avs_writedata(wdat), .i_avs_byteenable(ben),
		.o_avs_readdata(rdata), .o_avs_waitrequest(wait_o), .i_pad_in(pad_in),
		.o_pad_out(pad_out), .o_pad_oe(pad_oe), .o_pad_pullup_en(pu), .o_pad_receiver_en(rx),
		.o_pad_high_drive(hd), .i_crossbar_enable(xen), .i_crossbar_claim(xclaim),
		.i_crossbar_out(xout), .i_crossbar_oe(xoe), .o_crossbar_allowed(xallow),
		.o_pin_level(lvl), .i_ext_memory_out(emo), .i_ext_memory_oe(emoe),
		.i_debug_data_active(dba), .i_debug_data_out(dbo), .i_debug_data_oe(dboe),
		.o_debug_data_in(dbi), .o_pin_edge(edge_v), .o_event_any(ev_any));
	// free-running system clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	// a driven pin: push-pull always, open drain only when the latch is low
	function automatic logic [7:0] exp_oe(input logic [7:0] mode, input logic [7:0] latch);
		return mode | ~latch;
	endfunction
	task automatic end_of_test;
		if (err_count == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic chk_rd(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("BAD %0t read %h exp %h", $time, g, e);
		end
	endtask
	task automatic chk_pad(input logic [7:0] g, input logic [7:0] e);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("BAD %0t pads %h exp %h", $time, g, e);
		end
	endtask
	// one bus cycle: held until waitrequest is seen low at a rising edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] be, output logic [31:0] r);
		adr <= a;
		wdat <= d;
		ben <= be;
		if (w) wr_r <= 1'b1;
		else rd_r <= 1'b1;
		// waitrequest is looked at only on rising edges, data taken at that same edge
		@(posedge clk);
		while (wait_o !== 1'b0) @(posedge clk);
		r = rdata;
		wr_r <= 1'b0;
		rd_r <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(1'b1, a, {24'h0, d}, 4'h1, q);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		bus(1'b0, a, 32'h0, 4'hf, q);
		chk_rd(q, {24'h0, e});
	endtask
	// hang guard, far above the few hundred cycles the run needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			end_of_test;
		end
	end
	initial begin
		{rst_n, rd_r, wr_r, xen, dba, dbo, dboe, adr, ben, wdat} = '0;
		{xclaim, xout, xoe, emo, emoe} = '0;
		pad_in = {64{1'b1}};
		rnd = 32'h5fee;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (int k = 0; k < 5; k++) rdc(8'(8'h80 + k * 4), rv[k]);
		chk_pad(pad_oe[39:32], 8'h00);
		xen <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			rnd = lfsr(rnd);
			m = rnd[7:0];
			l = rnd[15:8];
			s = rnd[23:16];
			wr(8'h98, 8'hff);
			p = pad_in[39:32];
			pad_in[39:32] <= rnd[31:24];
			{xclaim, xout, xoe} <= {rnd, ~rnd, rnd, rnd, ~rnd, rnd};
			{emo, emoe, dbo, dboe} <= {rnd, rnd, ~rnd, rnd, rnd[1:0]};
			wr(8'h84, m);
			wr(8'h88, l);
			wr(8'h8c, s);
			wr(8'ha0, s);
			wr(8'h1c, {7'h0, i[0]});
			oe = exp_oe(m, l);
			chk_pad(pad_oe[39:32], oe);
			chk_pad(pad_out[39:32] & oe, l & oe);
			chk_pad(pu[39:32] & ~(oe & l), i[0] ? 8'h00 : ~oe);
			chk_pad(hd[39:32], s);
			chk_pad(rx[47:40], s);
			chk_pad(pu[47:40] & ~s, 8'h00);
			rdc(8'h94, rnd[31:24]);
			rdc(8'hb4, s);
			rdc(8'h98, p ^ rnd[31:24]);
			wr(8'h10, s);
			chk_pad(xallow[7:0], ~s);
			chk_pad(xallow[31:24], 8'h00);
		end
		// a write without its low lane, and an unmapped global slot
		bus(1'b1, 8'h84, 32'hff, 4'h0, q);
		rdc(8'h84, m);
		rdc(8'h3c, 8'h00);
		// port 5 handed to analog and port 1 kept as gpio, as software is told to
		wr(8'ha0, 8'h00);
		wr(8'ha4, 8'h00);
		wr(8'ha8, 8'hff);
		wr(8'hb0, 8'hff);
		wr(8'h30, 8'hff);
		chk_pad(pad_oe[47:40] | pu[47:40] | rx[47:40], 8'h00);
		rdc(8'hb4, 8'h00);
		chk_pad(xallow[15:8], 8'h00);
		// external memory takes port 4 over, crossbar ports untouched
		wr(8'h84, 8'hff);
		wr(8'h1c, 8'h02);
		chk_pad(pad_oe[39:32], emoe[39:32]);
		chk_pad(pad_out[39:32] & emoe[39:32], emo[39:32] & emoe[39:32]);
		chk_pad(xallow[23:16], 8'hff);
		wr(8'h1c, 8'h00);
		// debug line owns P7.0 and keeps it digital even with port 7 analog
		wr(8'he0, 8'h00);
		dba <= 1'b1;
		dbo <= 1'b0;
		dboe <= 1'b1;
		pad_in[56] <= 1'b0;
		repeat (4) @(posedge clk);
		chk_pad({5'h0, rx[56], pad_oe[56], pad_out[56]}, 8'h06);
		chk_pad({7'h0, dbi}, 8'h00);
		dba <= 1'b0;
		// clear every flag, then a single pad edge must raise the summary again
		for (int k = 0; k < 8; k++) wr(8'(8'h18 + k * 32), 8'hff);
		chk_pad({7'h0, ev_any}, 8'h00);
		pad_in[32] <= ~pad_in[32];
		repeat (4) @(posedge clk);
		chk_pad({7'h0, ev_any}, 8'h01);
		rdc(8'h98, 8'h01);
		// a second reset in mid-run must restore the same pad state
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rdc(8'h80, 8'hff);
		rdc(8'h84, 8'h00);
		chk_pad(pad_oe[39:32] | hd[39:32], 8'h00);
		chk_pad(pu[39:32] & rx[39:32], 8'hff);
		end_of_test;
	end
endmodule
bind port_pin_config_cell port_cell_sva chk_u (.i_clk_sys, .i_rst_n, .i_avs_read, .i_avs_write,
	.o_avs_readdata, .o_avs_waitrequest, .i_pad_in, .o_pad_out, .o_pad_oe, .o_pad_pullup_en,
	.o_pad_receiver_en, .o_pad_high_drive, .o_crossbar_allowed, .o_pin_level, .o_pin_edge,
	.o_event_any);
`default_nettype wire
